// File: vpcr_regs.sv
/*
 * vpcr_regs: control register bank for addresses 0x03, 0x06..0x0b and 0x0f.
 * Assumes a serial protocol engine on MCLK_IN presenting byte accesses;
 * vertical blank and sandcastle inputs come from pins and are synchronised.
 */
`timescale 1ns/1ps
module vpcr_regs (
    input  wire logic                 MCLK_IN,        // logic clock 200 MHz
    input  wire logic                 RST_B_IN,       // async reset, low
    input  wire logic                 CE_IN,          // clock enable
    input  wire vpcr_pkg::vpcr_acc_t  ACC_IN,         // byte access
    input  wire logic                 VBLANK_PIN_IN,  // vertical blank pin
    input  wire logic                 SANDCASTLE_IN,  // sandcastle vblank level
    input  wire logic                 HBLANK_IN,      // horizontal blank pin
    output logic [7:0]                RDATA_OUT,      // read data
    output logic [7:0]                NEXT_ADDR_OUT,  // address for next byte
    output logic [6:0]                CONTRAST_OUT,   // active contrast
    output logic [7:0]                LEVEL3_OUT,     // third level value
    output logic [7:0]                LEVEL4_OUT,     // fourth level value
    output vpcr_pkg::vpcr_ctl_t       CTL_OUT,        // decoded controls
    output logic                      OUT_BLANK_OUT,  // blank video output
    output logic                      ABORT_OUT       // abort analog work
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by the second
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync1_next;
    logic [2:0] sync2_next;

    always_comb begin
        sync1_next = {HBLANK_IN, SANDCASTLE_IN, VBLANK_PIN_IN};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else if (CE_IN) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] contrast_reg, contrast_next;
    logic [7:0] con_shadow_reg, con_shadow_next;
    logic [7:0] level3_reg, level3_next;
    logic [7:0] level4_reg, level4_next;
    logic [7:0] l4_shadow_reg, l4_shadow_next;
    logic [7:0] offset_reg, offset_next;
    logic [7:0] global_reg, global_next;
    logic [7:0] autostep_reg, autostep_next;
    logic [7:0] clamp_reg, clamp_next;
    logic       soft_reset_bit_bit_reg, soft_reset_bit_bit_next;
    logic [3:0] soft_reset_bit_cnt_reg, soft_reset_bit_cnt_next;
    logic       vb_prev_reg, vb_prev_next;
    logic [7:0] next_addr_reg, next_addr_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [6:0] con_out_reg, con_out_next;
    logic [7:0] l3_out_reg, l3_out_next;
    logic [7:0] l4_out_reg, l4_out_next;
    logic       blank_out_reg, blank_out_next;
    logic       abort_reg, abort_next;
    vpcr_pkg::vpcr_ctl_t ctl_reg, ctl_next;
    vpcr_pkg::vpcr_state_t state_reg, state_next;

    logic [7:0] acc_addr;
    logic       vblank_src;
    logic       vbl_en;
    logic       vb_start;

    // masked write merge: reserved bits stay zero
    function automatic logic [7:0] wmask(input logic [7:0] d, input logic [7:0] m);
        wmask = d & m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // vertical blank source and retrace edge
    always_comb begin
        acc_addr   = ACC_IN.first ? ACC_IN.addr : next_addr_reg;
        vbl_en     = clamp_reg[vpcr_pkg::CLP_VBL];
        // vertical blank pin when pin repurposing is off, else sandcastle
        vblank_src = clamp_reg[vpcr_pkg::CLP_L4EN] ? sync2_reg[1]
                                                   : sync2_reg[0];
        vb_start   = vbl_en & vblank_src & ~vb_prev_reg;
        vb_prev_next = vblank_src;
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes, soft reset sequence and address stepping
    always_comb begin
        contrast_next  = contrast_reg;
        con_shadow_next = con_shadow_reg;
        level3_next    = level3_reg;
        level4_next    = level4_reg;
        l4_shadow_next = l4_shadow_reg;
        offset_next    = offset_reg;
        global_next    = global_reg;
        autostep_next  = autostep_reg;
        clamp_next     = clamp_reg;
        soft_reset_bit_bit_next  = soft_reset_bit_bit_reg;
        soft_reset_bit_cnt_next  = soft_reset_bit_cnt_reg;
        state_next     = state_reg;
        next_addr_next = next_addr_reg;
        abort_next     = 1'b0;
        case (state_reg)
            vpcr_pkg::VPCR_RUN: begin
                if (ACC_IN.wr) begin
                    case (acc_addr)
                        vpcr_pkg::ADDR_CONTRAST: begin
                            con_shadow_next = wmask(ACC_IN.data, vpcr_pkg::MASK_CONTRAST);
                            if (!vbl_en)
                                contrast_next = wmask(ACC_IN.data, vpcr_pkg::MASK_CONTRAST);
                        end
                        vpcr_pkg::ADDR_LEVEL3: level3_next = ACC_IN.data;
                        vpcr_pkg::ADDR_LEVEL4: begin
                            l4_shadow_next = ACC_IN.data;
                            if (!vbl_en)
                                level4_next = ACC_IN.data;
                        end
                        vpcr_pkg::ADDR_OFFSET:
                            offset_next = wmask(ACC_IN.data, vpcr_pkg::MASK_OFFSET);
                        vpcr_pkg::ADDR_GLOBAL:
                            global_next = wmask(ACC_IN.data, vpcr_pkg::MASK_GLOBAL);
                        vpcr_pkg::ADDR_AUTOSTEP:
                            autostep_next = wmask(ACC_IN.data, vpcr_pkg::MASK_AUTOSTEP);
                        vpcr_pkg::ADDR_CLAMP:
                            clamp_next = wmask(ACC_IN.data, vpcr_pkg::MASK_CLAMP);
                        vpcr_pkg::ADDR_SRESET: begin
                            if (ACC_IN.data[vpcr_pkg::SRS_BIT]) begin
                                soft_reset_bit_bit_next = 1'b1;
                                soft_reset_bit_cnt_next = vpcr_pkg::SOFT_RESET_BIT_CYCLES;
                                state_next    = vpcr_pkg::VPCR_SOFT_RESET_BIT;
                            end
                        end
                        default: ;
                    endcase
                end
                // retrace copy of deferred values; a write in the retrace cycle waits for the next retrace
                if (vb_start) begin
                    contrast_next = con_shadow_reg;
                    level4_next   = l4_shadow_reg;
                end
            end
            vpcr_pkg::VPCR_SOFT_RESET_BIT: begin
                // analog work aborted; serial engine is outside and untouched
                abort_next     = 1'b1;
                contrast_next  = vpcr_pkg::RST_CONTRAST;
                con_shadow_next = vpcr_pkg::RST_CONTRAST;
                level3_next    = vpcr_pkg::RST_LEVEL;
                level4_next    = vpcr_pkg::RST_LEVEL;
                l4_shadow_next = vpcr_pkg::RST_LEVEL;
                offset_next    = vpcr_pkg::RST_OFFSET;
                global_next    = vpcr_pkg::RST_GLOBAL;
                autostep_next  = vpcr_pkg::RST_AUTOSTEP;
                clamp_next     = vpcr_pkg::RST_CLAMP;
                soft_reset_bit_cnt_next  = soft_reset_bit_cnt_reg - 4'h1;
                if (soft_reset_bit_cnt_reg == 4'h1) begin
                    soft_reset_bit_bit_next = 1'b0;
                    state_next    = vpcr_pkg::VPCR_RUN;
                end
            end
            default: state_next = vpcr_pkg::VPCR_RUN;
        endcase
        // address stepping continues across a soft reset so a burst completes
        if (ACC_IN.wr || ACC_IN.rd) begin
            if (!autostep_reg[vpcr_pkg::AST_DIS])
                next_addr_next = acc_addr + 8'h01;
            else
                next_addr_next = acc_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux and output decode
    always_comb begin
        case (acc_addr)
            vpcr_pkg::ADDR_CONTRAST: rdata_next = con_shadow_reg;
            vpcr_pkg::ADDR_LEVEL3:   rdata_next = level3_reg;
            vpcr_pkg::ADDR_LEVEL4:   rdata_next = l4_shadow_reg;
            vpcr_pkg::ADDR_OFFSET:   rdata_next = offset_reg;
            vpcr_pkg::ADDR_GLOBAL:   rdata_next = global_reg;
            vpcr_pkg::ADDR_AUTOSTEP: rdata_next = autostep_reg;
            vpcr_pkg::ADDR_CLAMP:    rdata_next = clamp_reg;
            vpcr_pkg::ADDR_SRESET:   rdata_next = {7'h00, soft_reset_bit_bit_reg};
            default:                 rdata_next = 8'h00;
        endcase
        if (!ACC_IN.rd)
            rdata_next = rdata_reg;
        con_out_next = contrast_reg[6:0];
        l3_out_next  = level3_reg;
        l4_out_next  = level4_reg;
        ctl_next.video_offset_field =
            offset_reg[vpcr_pkg::OFS_MSB:vpcr_pkg::OFS_LSB];
        ctl_next.overlay_contrast_field =
            offset_reg[vpcr_pkg::OSD_MSB:vpcr_pkg::OSD_LSB];
        ctl_next.video_blank       = global_reg[vpcr_pkg::GLB_BLANK];
        ctl_next.power_save        = global_reg[vpcr_pkg::GLB_PSAVE];
        ctl_next.level_range_halve = global_reg[vpcr_pkg::GLB_HALVE];
        ctl_next.level_mix         = global_reg[vpcr_pkg::GLB_MIX];
        ctl_next.overlay_only      = clamp_reg[vpcr_pkg::CLP_OOR];
        ctl_next.level4_pin_en     = clamp_reg[vpcr_pkg::CLP_L4EN];
        ctl_next.clamp_negative    = clamp_reg[vpcr_pkg::CLP_POL];
        ctl_next.sandcastle_vblank = vbl_en & clamp_reg[vpcr_pkg::CLP_L4EN];
        // overall blank: horizontal, plus vertical when enabled, plus forced
        blank_out_next = sync2_reg[2] | (vbl_en & vblank_src)
                       | global_reg[vpcr_pkg::GLB_BLANK]
                       | clamp_reg[vpcr_pkg::CLP_OOR];
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            contrast_reg   <= vpcr_pkg::RST_CONTRAST;
            con_shadow_reg <= vpcr_pkg::RST_CONTRAST;
            level3_reg     <= vpcr_pkg::RST_LEVEL;
            level4_reg     <= vpcr_pkg::RST_LEVEL;
            l4_shadow_reg  <= vpcr_pkg::RST_LEVEL;
            offset_reg     <= vpcr_pkg::RST_OFFSET;
            global_reg     <= vpcr_pkg::RST_GLOBAL;
            autostep_reg   <= vpcr_pkg::RST_AUTOSTEP;
            clamp_reg      <= vpcr_pkg::RST_CLAMP;
            soft_reset_bit_bit_reg   <= 1'b0;
            soft_reset_bit_cnt_reg   <= 4'h0;
            state_reg      <= vpcr_pkg::VPCR_RUN;
            vb_prev_reg    <= 1'b0;
            next_addr_reg  <= 8'h00;
            rdata_reg      <= 8'h00;
            con_out_reg    <= vpcr_pkg::RST_CONTRAST[6:0];
            l3_out_reg     <= vpcr_pkg::RST_LEVEL;
            l4_out_reg     <= vpcr_pkg::RST_LEVEL;
            ctl_reg        <= '0;
            blank_out_reg  <= 1'b0;
            abort_reg      <= 1'b0;
        end else if (CE_IN) begin
            contrast_reg   <= contrast_next;
            con_shadow_reg <= con_shadow_next;
            level3_reg     <= level3_next;
            level4_reg     <= level4_next;
            l4_shadow_reg  <= l4_shadow_next;
            offset_reg     <= offset_next;
            global_reg     <= global_next;
            autostep_reg   <= autostep_next;
            clamp_reg      <= clamp_next;
            soft_reset_bit_bit_reg   <= soft_reset_bit_bit_next;
            soft_reset_bit_cnt_reg   <= soft_reset_bit_cnt_next;
            state_reg      <= state_next;
            vb_prev_reg    <= vb_prev_next;
            next_addr_reg  <= next_addr_next;
            rdata_reg      <= rdata_next;
            con_out_reg    <= con_out_next;
            l3_out_reg     <= l3_out_next;
            l4_out_reg     <= l4_out_next;
            ctl_reg        <= ctl_next;
            blank_out_reg  <= blank_out_next;
            abort_reg      <= abort_next;
        end
    end

    // every output straight from a flip-flop
    always_comb begin
        RDATA_OUT     = rdata_reg;
        NEXT_ADDR_OUT = next_addr_reg;
        CONTRAST_OUT  = con_out_reg;
        LEVEL3_OUT    = l3_out_reg;
        LEVEL4_OUT    = l4_out_reg;
        CTL_OUT       = ctl_reg;
        OUT_BLANK_OUT = blank_out_reg;
        ABORT_OUT     = abort_reg;
    end

endmodule // vpcr_regs

// File: vpcr_pkg.sv
/*
 * vpcr_pkg: constants, field positions, reset values and carrier types for
 * the video pre-amp upper control register bank.
 * Assumes a serial protocol engine outside that presents byte accesses.
 */
package vpcr_pkg;
    localparam logic [7:0] ADDR_CONTRAST = 8'h03;
    localparam logic [7:0] ADDR_LEVEL3   = 8'h06;
    localparam logic [7:0] ADDR_LEVEL4   = 8'h07;
    localparam logic [7:0] ADDR_OFFSET   = 8'h08;
    localparam logic [7:0] ADDR_GLOBAL   = 8'h09;
    localparam logic [7:0] ADDR_AUTOSTEP = 8'h0a;
    localparam logic [7:0] ADDR_CLAMP    = 8'h0b;
    localparam logic [7:0] ADDR_SRESET   = 8'h0f;

    localparam logic [7:0] RST_CONTRAST  = 8'h60;
    localparam logic [7:0] RST_LEVEL     = 8'h80;
    localparam logic [7:0] RST_OFFSET    = 8'h15;
    localparam logic [7:0] RST_GLOBAL    = 8'h00;
    localparam logic [7:0] RST_AUTOSTEP  = 8'h00;
    localparam logic [7:0] RST_CLAMP     = 8'h04;

    // writable bit masks; everything else is reserved or must-be-zero
    localparam logic [7:0] MASK_CONTRAST = 8'h7f;
    localparam logic [7:0] MASK_OFFSET   = 8'h1f;
    localparam logic [7:0] MASK_GLOBAL   = 8'h1b;
    localparam logic [7:0] MASK_AUTOSTEP = 8'h01;
    localparam logic [7:0] MASK_CLAMP    = 8'h0f;

    localparam int OFS_LSB = 0;
    localparam int OFS_MSB = 2;
    localparam int OSD_LSB = 3;
    localparam int OSD_MSB = 4;
    localparam int GLB_BLANK = 0;
    localparam int GLB_PSAVE = 1;
    localparam int GLB_HALVE = 3;
    localparam int GLB_MIX   = 4;
    localparam int AST_DIS   = 0;
    localparam int CLP_OOR   = 0;
    localparam int CLP_VBL   = 1;
    localparam int CLP_L4EN  = 2;
    localparam int CLP_POL   = 3;
    localparam int SRS_BIT   = 0;

    // soft reset sequence length in clocks
    localparam logic [3:0] SOFT_RESET_BIT_CYCLES = 4'h4;

    // one byte access from the serial engine
    typedef struct packed {
        logic       wr;     // write strobe
        logic       rd;     // read strobe
        logic       first;  // first data byte: take addr as given
        logic [7:0] addr;   // register address from serial engine
        logic [7:0] data;   // write data
    } vpcr_acc_t;

    // decoded controls toward analog side
    typedef struct packed {
        logic [2:0] video_offset_field;
        logic [1:0] overlay_contrast_field;
        logic       video_blank;
        logic       power_save;
        logic       level_range_halve;
        logic       level_mix;
        logic       overlay_only;
        logic       level4_pin_en;
        logic       clamp_negative;
        logic       sandcastle_vblank;
    } vpcr_ctl_t;

    typedef enum logic [1:0] {
        VPCR_RUN  = 2'b01,
        VPCR_SOFT_RESET_BIT = 2'b10
    } vpcr_state_t;
endpackage

// File: vpcr_regs_monitor.sv
/*
 * vpcr_regs_monitor: port-level assertions for the control register bank.
 * Assumes binding onto vpcr_regs, one clock, async active-low reset.
 */
`timescale 1ns/1ps
module vpcr_regs_monitor (
    input  wire logic                MCLK_IN,       // logic clock
    input  wire logic                RST_B_IN,      // async reset, low
    input  wire logic                CE_IN,         // clock enable
    input  wire vpcr_pkg::vpcr_acc_t ACC_IN,        // byte access
    input  wire logic                HBLANK_IN,     // horizontal blank pin
    input  wire logic [7:0]          LEVEL3_OUT,    // third level value
    input  wire vpcr_pkg::vpcr_ctl_t CTL_OUT,       // decoded controls
    input  wire logic                OUT_BLANK_OUT, // blank video output
    input  wire logic                ABORT_OUT      // soft reset busy
);
    default clocking @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    ////////////////////////////////////////////////////////////////////////
    // a burst start outside soft reset; later bytes may step the address
    logic wr_ok;
    logic soft_reset_bit_seen_reg;
    assign wr_ok = ACC_IN.wr && ACC_IN.first && CE_IN && !ABORT_OUT && !soft_reset_bit_seen_reg;
    // the bank already ignores writes in the cycle after a soft reset is
    // taken, one cycle before ABORT_OUT rises, so that cycle is masked here
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN)
            soft_reset_bit_seen_reg <= 1'b0;
        else if (CE_IN)
            soft_reset_bit_seen_reg <= wr_ok && ACC_IN.addr == 8'h0f && ACC_IN.data[0];
    end
    ////////////////////////////////////////////////////////////////////////
    a_level3_follow: assert property (wr_ok && ACC_IN.addr == 8'h06
        |-> ##2 LEVEL3_OUT == $past(ACC_IN.data, 2)) else $error("level three mismatch");
    a_offset_decode: assert property (wr_ok && ACC_IN.addr == 8'h08
        |-> ##2 CTL_OUT.video_offset_field == $past(ACC_IN.data[2:0], 2)
        && CTL_OUT.overlay_contrast_field == $past(ACC_IN.data[4:3], 2))
        else $error("offset field mismatch");
    a_global_decode: assert property (wr_ok && ACC_IN.addr == 8'h09
        |-> ##2 {CTL_OUT.level_mix, CTL_OUT.level_range_halve, CTL_OUT.power_save,
        CTL_OUT.video_blank} == {$past(ACC_IN.data[4:3], 2), $past(ACC_IN.data[1:0], 2)})
        else $error("global field mismatch");
    a_clamp_decode: assert property (wr_ok && ACC_IN.addr == 8'h0b
        |-> ##2 {CTL_OUT.clamp_negative, CTL_OUT.level4_pin_en, CTL_OUT.overlay_only,
        CTL_OUT.sandcastle_vblank} == {$past(ACC_IN.data[3:2], 2), $past(ACC_IN.data[0], 2),
        $past(ACC_IN.data[1], 2) & $past(ACC_IN.data[2], 2)})
        else $error("clamp field mismatch");
    a_soft_reset_bit_abort: assert property (wr_ok && ACC_IN.addr == 8'h0f && ACC_IN.data[0]
        |-> ##[1:2] ABORT_OUT) else $error("soft reset did not abort");
    a_abort_ends: assert property ($rose(ABORT_OUT) |-> ##[2:5] !ABORT_OUT)
        else $error("soft reset never finished");
    a_blank_force: assert property ((CTL_OUT.video_blank || CTL_OUT.overlay_only)
        && $past(CTL_OUT.video_blank || CTL_OUT.overlay_only) |-> OUT_BLANK_OUT)
        else $error("blank not forced");
    a_hblank_pass: assert property (HBLANK_IN [*5] |-> OUT_BLANK_OUT)
        else $error("horizontal blank lost");
endmodule // vpcr_regs_monitor

bind vpcr_regs vpcr_regs_monitor vpcr_regs_monitor_i (.MCLK_IN(MCLK_IN),
    .RST_B_IN(RST_B_IN), .CE_IN(CE_IN), .ACC_IN(ACC_IN), .HBLANK_IN(HBLANK_IN),
    .LEVEL3_OUT(LEVEL3_OUT), .CTL_OUT(CTL_OUT), .OUT_BLANK_OUT(OUT_BLANK_OUT),
    .ABORT_OUT(ABORT_OUT));

// File: vpcr_host_model.sv
/*
 * vpcr_host_model: host side that issues single byte accesses.
 * Assumes accesses are driven at one rising edge and taken at the next, with read data sampled just after that same edge.
 */
`timescale 1ns/1ps
module vpcr_host_model (
    input  wire logic                clk_in,   // logic clock
    input  wire logic [7:0]          rdata_in, // read data from bank
    output vpcr_pkg::vpcr_acc_t      acc_out   // byte access
);
    initial acc_out = '0;
    ////////////////////////////////////////////////////////////////////////
    // one access; only bits 5 and 2 of the global register and bit 1 of autostep
    // go out as zero, other must-be-zero bits pass through for the bank to drop
    task automatic xfer(input logic w, input logic f, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [7:0] dm;
        dm = d;
        if (w && a == vpcr_pkg::ADDR_GLOBAL) dm = d & 8'hdb;
        if (w && a == vpcr_pkg::ADDR_AUTOSTEP) dm = d & 8'hfd;
        @(posedge clk_in);
        acc_out <= {w, !w, f, a, dm};
        @(posedge clk_in);
        // idle bus shows inverted values so a stale byte is never reused
        acc_out <= {3'h0, ~a, ~dm};
        #1 q = rdata_in;
    endtask
endmodule // vpcr_host_model

// File: tb_top.sv
/*
 * tb_top: directed register tests for vpcr_regs via the host model.
 * Assumes a 200 MHz clock and blank inputs driven by this bench.
 */
`timescale 1ns/1ps
module tb_top;
    logic                clk, rst_b, vblank, sandcastle, hblank, out_blank, abort, ce;
    logic [7:0]          rdata, nxt, level3, level4, q;
    logic [6:0]          contrast;
    vpcr_pkg::vpcr_acc_t acc;
    vpcr_pkg::vpcr_ctl_t ctl;
    int                  bad_count, compares;
    logic [7:0]          addrs [8] = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0f};
    logic [7:0]          defs [8] = '{8'h60, 8'h80, 8'h80, 8'h15, 8'h00, 8'h00, 8'h04, 8'h00};
    ////////////////////////////////////////////////////////////////////////
    vpcr_regs vpcr_regs_i (.MCLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .ACC_IN(acc),
        .VBLANK_PIN_IN(vblank), .SANDCASTLE_IN(sandcastle), .HBLANK_IN(hblank),
        .RDATA_OUT(rdata), .NEXT_ADDR_OUT(nxt), .CONTRAST_OUT(contrast),
        .LEVEL3_OUT(level3), .LEVEL4_OUT(level4), .CTL_OUT(ctl),
        .OUT_BLANK_OUT(out_blank), .ABORT_OUT(abort));
    vpcr_host_model vpcr_host_model_i (.clk_in(clk), .rdata_in(rdata), .acc_out(acc));
    // 5 ns clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_byte({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic f);
        vpcr_host_model_i.xfer(1'b1, f, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        vpcr_host_model_i.xfer(1'b0, 1'b1, a, 8'h00, q);
        chk_byte(q, exp, "read data");
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        vblank = 1'b0;
        sandcastle = 1'b0;
        hblank = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rd(addrs[i], defs[i]);
        // burst: later bytes step the address, reserved bits drop
        wr(8'h06, 8'haa, 1'b1);
        wr(8'h00, 8'h55, 1'b0);
        wr(8'h00, 8'hfe, 1'b0);
        wr(8'h09, 8'hda, 1'b1);
        settle(3);
        chk_byte(level3, 8'haa, "level three");
        chk_byte(level4, 8'h55, "level four");
        chk_byte({5'h00, ctl.video_offset_field}, 8'h06, "video offset");
        chk_byte({6'h00, ctl.overlay_contrast_field}, 8'h03, "overlay contrast");
        chk_bit(ctl.power_save, 1'b1, "power save");
        chk_bit(ctl.level_range_halve, 1'b1, "range halve");
        chk_bit(ctl.level_mix, 1'b1, "level mix");
        chk_bit(out_blank, 1'b0, "blank idle");
        chk_byte(nxt, 8'h0a, "next address");
        rd(8'h08, 8'h1e);
        rd(8'h09, 8'h1a);
        wr(8'h09, 8'h01, 1'b1);
        settle(3);
        chk_bit(out_blank, 1'b1, "blank forced");
        wr(8'h09, 8'h00, 1'b1);
        // autostep off: second byte rewrites the same address
        wr(8'h0a, 8'h01, 1'b1);
        wr(8'h06, 8'h11, 1'b1);
        wr(8'h00, 8'h22, 1'b0);
        settle(3);
        chk_byte(level3, 8'h22, "no step level three");
        chk_byte(level4, 8'h55, "no step level four");
        // clock enable low: the write is not taken and nothing moves
        @(posedge clk) ce <= 1'b0;
        wr(8'h06, 8'h77, 1'b1);
        settle(3);
        chk_byte(level3, 8'h22, "frozen level three");
        @(posedge clk) ce <= 1'b1;
        rd(8'h0a, 8'h01);
        wr(8'h0a, 8'h00, 1'b1);
        // overlay only with negative clamp, then pin given to vertical blank
        wr(8'h0b, 8'h0d, 1'b1);
        settle(3);
        chk_bit(out_blank, 1'b1, "overlay only blank");
        chk_bit(ctl.clamp_negative, 1'b1, "clamp polarity");
        wr(8'h0b, 8'hf0, 1'b1);
        settle(3);
        chk_bit(ctl.level4_pin_en, 1'b0, "pin disabled");
        rd(8'h0b, 8'h00);
        // deferral from the vertical blank pin; a vertical source is present
        wr(8'h0b, 8'h02, 1'b1);
        wr(8'h07, 8'h33, 1'b1);
        settle(8);
        chk_byte(level4, 8'h55, "level four held");
        rd(8'h07, 8'h33);
        @(posedge clk) vblank <= 1'b1;
        settle(8);
        chk_byte(level4, 8'h33, "level four at retrace");
        chk_bit(out_blank, 1'b1, "vertical blank");
        @(posedge clk) vblank <= 1'b0;
        // deferral from sandcastle, positive clamp kept
        wr(8'h0b, 8'h06, 1'b1);
        wr(8'h03, 8'h11, 1'b1);
        settle(8);
        chk_byte({1'b0, contrast}, 8'h60, "contrast held");
        chk_bit(ctl.sandcastle_vblank, 1'b1, "sandcastle source");
        @(posedge clk) sandcastle <= 1'b1;
        settle(8);
        chk_byte({1'b0, contrast}, 8'h11, "contrast at retrace");
        @(posedge clk) sandcastle <= 1'b0;
        // gating off: writes land at once, horizontal blank still passes
        wr(8'h0b, 8'h04, 1'b1);
        wr(8'h07, 8'h44, 1'b1);
        settle(3);
        chk_byte(level4, 8'h44, "level four direct");
        @(posedge clk) hblank <= 1'b1;
        settle(6);
        chk_bit(out_blank, 1'b1, "horizontal blank");
        @(posedge clk) hblank <= 1'b0;
        // unmapped address, then soft reset
        wr(8'h0c, 8'h5a, 1'b1);
        rd(8'h0c, 8'h00);
        wr(8'h0f, 8'h01, 1'b1);
        settle(1);
        chk_bit(abort, 1'b1, "abort during soft reset");
        settle(7);
        chk_bit(abort, 1'b0, "abort ended");
        for (int i = 0; i < 8; i++) rd(addrs[i], defs[i]);
        chk_bit(ctl.level4_pin_en, 1'b1, "pin after soft reset");
        summarize();
    end
endmodule // tb_top
